//--- verilog/vsss_ctrl.sv
// Purpose: digital control core of a quasi-resonant flyback controller
// Assumes: comparator inputs asynchronous; 25 MHz clock
// Notes: analog thresholds and timers live outside
`timescale 1ns/1ps
`include "vsss_regs.svh"

module vsss_ctrl #(
    parameter int UPD_CYC = `VSSS_UPD_CYC,
    parameter int SS_STEP_CYC = `VSSS_SS_STEP_CYC
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic supply_on,
    input wire logic zero_cross_input,
    input wire logic fb_above_low,
    input wire logic fb_above_high,
    input wire logic fb_above_reset,
    input wire logic cs_trip,
    input wire logic ring_supp_done,
    input wire logic max_off_interval,
    input wire logic line_high,
    input wire logic [9:0] ext_limit_mv,
    output logic startup_charge_en,
    output logic gate_drive,
    output logic [9:0] cs_limit_mv,
    output logic [2:0] skip_count,
    output logic [2:0] zc_count,
    output logic softstart_active,
    output logic hold_thr_sel
);

    // ==========================================
    // Input synchronisers
    // ==========================================
    localparam int NSYNC = 9;
    logic [NSYNC-1:0] raw_in;
    logic [NSYNC-1:0] sync1_q;
    logic [NSYNC-1:0] sync2_q;

    assign raw_in = {supply_on, zero_cross_input, fb_above_low,
                     fb_above_high, fb_above_reset, cs_trip,
                     ring_supp_done, max_off_interval, line_high};

    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi++) begin : g_sync
            always_ff @(posedge clk or negedge rstn) begin
                if (!rstn) begin
                    sync1_q[gi] <= 1'b0;
                    sync2_q[gi] <= 1'b0;
                end else begin
                    sync1_q[gi] <= raw_in[gi];
                    sync2_q[gi] <= sync1_q[gi];
                end
            end
        end
    endgenerate

    logic s_supply;
    logic s_zc;
    vsss_pkg::vsss_fb_t s_fb;
    logic s_cs;
    logic s_ring;
    logic s_maxoff;
    logic s_line;

    assign s_supply = sync2_q[8];
    assign s_zc = sync2_q[7];
    assign s_fb.above_low = sync2_q[6];
    assign s_fb.above_high = sync2_q[5];
    assign s_fb.above_reset = sync2_q[4];
    assign s_cs = sync2_q[3];
    assign s_ring = sync2_q[2];
    assign s_maxoff = sync2_q[1];
    assign s_line = sync2_q[0];

    // ==========================================
    // Start-up and soft-start
    // ==========================================
    vsss_pkg::vsss_ss_t ss_q;
    logic [31:0] ss_cnt_q;
    logic ss_tick;
    logic running;
    logic ss_cnt_clr;

    assign ss_tick = (ss_cnt_q == 32'(SS_STEP_CYC - 1));
    assign running = (ss_q != vsss_pkg::VSSS_SS_OFF);
    assign ss_cnt_clr = !s_supply || ss_tick ||
                        (ss_q == vsss_pkg::VSSS_SS_DONE);

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ss_q <= vsss_pkg::VSSS_SS_OFF;
        end else if (!s_supply) begin
            ss_q <= vsss_pkg::VSSS_SS_OFF;
        end else begin
            case (ss_q)
                vsss_pkg::VSSS_SS_OFF: ss_q <= vsss_pkg::VSSS_SS_ST0;
                vsss_pkg::VSSS_SS_ST0:
                    if (ss_tick) ss_q <= vsss_pkg::VSSS_SS_ST1;
                vsss_pkg::VSSS_SS_ST1:
                    if (ss_tick) ss_q <= vsss_pkg::VSSS_SS_ST2;
                vsss_pkg::VSSS_SS_ST2:
                    if (ss_tick) ss_q <= vsss_pkg::VSSS_SS_ST3;
                vsss_pkg::VSSS_SS_ST3:
                    if (ss_tick) ss_q <= vsss_pkg::VSSS_SS_DONE;
                vsss_pkg::VSSS_SS_DONE: ss_q <= vsss_pkg::VSSS_SS_DONE;
                default: ss_q <= vsss_pkg::VSSS_SS_OFF;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ss_cnt_q <= 32'h0;
        end else if (ss_cnt_clr) begin
            ss_cnt_q <= 32'h0;
        end else if (running) begin
            ss_cnt_q <= ss_cnt_q + 32'h1;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            startup_charge_en <= 1'b1;
        end else begin
            startup_charge_en <= !running;
        end
    end

    // ==========================================
    // Current limit and status outputs
    // ==========================================
    function automatic logic [9:0] step_limit(input vsss_pkg::vsss_ss_t s);
        case (s)
            vsss_pkg::VSSS_SS_ST0: step_limit = `VSSS_LIM_MV0;
            vsss_pkg::VSSS_SS_ST1: step_limit = `VSSS_LIM_MV1;
            vsss_pkg::VSSS_SS_ST2: step_limit = `VSSS_LIM_MV2;
            vsss_pkg::VSSS_SS_ST3: step_limit = `VSSS_LIM_MV3;
            vsss_pkg::VSSS_SS_DONE: step_limit = `VSSS_LIM_FINAL;
            default: step_limit = `VSSS_LIM_MV0;
        endcase
    endfunction

    logic [9:0] lim_d;
    assign lim_d = step_limit(ss_q);

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cs_limit_mv <= `VSSS_LIM_MV0;
        end else begin
            cs_limit_mv <= (ext_limit_mv < lim_d) ? ext_limit_mv : lim_d;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            softstart_active <= 1'b0;
        end else begin
            softstart_active <= running && ss_q != vsss_pkg::VSSS_SS_DONE;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            hold_thr_sel <= 1'b0;
        end else begin
            hold_thr_sel <= s_line;
        end
    end

    // ==========================================
    // Update period timer
    // ==========================================
    logic [31:0] upd_cnt_q;
    logic upd_tick;
    vsss_pkg::vsss_fb_t seen_q;
    vsss_pkg::vsss_fb_t seen_now;

    assign upd_tick = running && (upd_cnt_q == 32'(UPD_CYC - 1));
    assign seen_now = seen_q | s_fb;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            upd_cnt_q <= 32'h0;
        end else if (!running || upd_tick) begin
            upd_cnt_q <= 32'h0;
        end else begin
            upd_cnt_q <= upd_cnt_q + 32'h1;
        end
    end

    // ==========================================
    // Sticky feedback flags
    // ==========================================
    // sticky flags, cleared each period
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            seen_q <= '0;
        end else if (!running || upd_tick) begin
            seen_q <= '0;
        end else begin
            seen_q <= seen_now;
        end
    end

    // ==========================================
    // Counter decision
    // ==========================================
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            skip_count <= `VSSS_UD_RST;
        end else if (!running) begin
            skip_count <= `VSSS_UD_RST;
        end else if (upd_tick) begin
            if (seen_now.above_reset) begin
                skip_count <= `VSSS_UD_MIN;
            end else if (seen_now.above_high) begin
                if (skip_count > `VSSS_UD_MIN)
                    skip_count <= skip_count - 3'h1;
            end else if (!seen_now.above_low) begin
                if (skip_count < `VSSS_UD_MAX)
                    skip_count <= skip_count + 3'h1;
            end
        end
    end

    // ==========================================
    // Zero-crossing edge detect and count
    // ==========================================
    logic zc_prev_q;
    logic zc_fall;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            zc_prev_q <= 1'b0;
        end else begin
            zc_prev_q <= s_zc;
        end
    end

    assign zc_fall = zc_prev_q && !s_zc;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            zc_count <= 3'h0;
        end else if (gate_drive) begin
            zc_count <= 3'h0;
        end else if (zc_fall && zc_count < `VSSS_ZC_MAX) begin
            zc_count <= zc_count + 3'h1;
        end
    end

    // ==========================================
    // Gate drive
    // ==========================================
    logic turn_on;
    logic turn_off;
    logic valley_ok;

    assign valley_ok = s_ring && (zc_count >= skip_count);
    assign turn_on = running && !gate_drive && (valley_ok || s_maxoff);
    assign turn_off = gate_drive && s_cs;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            gate_drive <= 1'b0;
        end else if (!running || turn_off) begin
            gate_drive <= 1'b0;
        end else if (turn_on) begin
            gate_drive <= 1'b1;
        end
    end

endmodule // vsss_ctrl

//--- verilog/vsss_regs.svh
// Purpose: constants for the valley-skip and soft-start core
// Assumes: 25 MHz clock, 40 ns period
// Notes: times in microseconds, counts derived from them
`ifndef VSSS_REGS_SVH
`define VSSS_REGS_SVH

`define VSSS_CLK_KHZ 25000
`define VSSS_UPD_US 48000
`define VSSS_UPD_CYC ((`VSSS_UPD_US * `VSSS_CLK_KHZ) / 1000)
`define VSSS_SS_US 12000
`define VSSS_SS_STEPS 4
`define VSSS_SS_STEP_CYC \
    ((`VSSS_SS_US * `VSSS_CLK_KHZ) / (1000 * `VSSS_SS_STEPS))
`define VSSS_UD_MIN 3'h1
`define VSSS_UD_MAX 3'h7
`define VSSS_UD_RST 3'h1
`define VSSS_ZC_MAX 3'h7
// Current limit codes, millivolts: 0.32 V start, 1 V final
`define VSSS_LIM_MV0 10'h140
`define VSSS_LIM_MV1 10'h1F0
`define VSSS_LIM_MV2 10'h2A0
`define VSSS_LIM_MV3 10'h350
`define VSSS_LIM_FINAL 10'h3E8

`endif

//--- verilog/vsss_pkg.sv
// Purpose: types for the valley-skip and soft-start core
// Assumes: nothing
// Notes: soft-start states in Gray order
package vsss_pkg;
    typedef enum logic [2:0] {
        VSSS_SS_OFF = 3'h0,
        VSSS_SS_ST0 = 3'h1,
        VSSS_SS_ST1 = 3'h3,
        VSSS_SS_ST2 = 3'h2,
        VSSS_SS_ST3 = 3'h6,
        VSSS_SS_DONE = 3'h7
    } vsss_ss_t;

    typedef struct packed {
        logic above_low;
        logic above_high;
        logic above_reset;
    } vsss_fb_t;
endpackage

//--- bench/vsss_chk.sv
// Purpose: port-level checker for vsss_ctrl
// Assumes: one clock, async active-low reset
// Notes: bound to every vsss_ctrl instance
`timescale 1ns/1ps
module vsss_chk #(
    parameter int UPD_CYC = 1200000,
    parameter int SS_STEP_CYC = 75000
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic supply_on,
    input wire logic cs_trip,
    input wire logic max_off_interval,
    input wire logic ring_supp_done,
    input wire logic startup_charge_en,
    input wire logic gate_drive,
    input wire logic [9:0] cs_limit_mv,
    input wire logic [2:0] skip_count,
    input wire logic [2:0] zc_count,
    input wire logic softstart_active
);
    // ==========
    // Soft-start length
    int ss_n_q;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn)
            ss_n_q <= 0;
        else
            ss_n_q <= softstart_active ? ss_n_q + 1 : 0;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    skip_step_a: assert property (
        $changed(skip_count) |-> skip_count == 3'h1 ||
        skip_count == $past(skip_count) + 3'h1 ||
        skip_count == $past(skip_count) - 3'h1) else $error("skip jump");
    skip_hold_a: assert property (
        $changed(skip_count) |=> $stable(skip_count) [*8])
        else $error("skip changed twice");
    zc_clear_a: assert property (
        $rose(gate_drive) |=> zc_count == 3'h0) else $error("zc not cleared");
    zc_step_a: assert property (
        !gate_drive && !$past(gate_drive) |-> zc_count == $past(zc_count) ||
        zc_count == $past(zc_count) + 3'h1) else $error("zc count jump");
    gate_on_a: assert property (
        $rose(gate_drive) |-> $past(zc_count) >= $past(skip_count) ||
        zc_count >= skip_count || $past(max_off_interval, 3))
        else $error("gate on early");
    gate_off_a: assert property (
        $fell(gate_drive) |-> $past(cs_trip, 3) || !$past(supply_on, 4))
        else $error("gate off uncaused");
    ring_wait_a: assert property (
        $rose(gate_drive) |-> $past(ring_supp_done, 3) ||
        $past(max_off_interval, 3)) else $error("gate on in ringing");
    charge_off_a: assert property (
        $fell(startup_charge_en) |-> softstart_active)
        else $error("charge off without soft-start");
    ss_limit_a: assert property (
        softstart_active |-> cs_limit_mv <= 10'h350)
        else $error("limit high in soft-start");
    ss_len_a: assert property (
        $fell(softstart_active) && !startup_charge_en |->
        ss_n_q == 4 * SS_STEP_CYC) else $error("soft-start length");
    cover property ($rose(gate_drive));
    cover property ($fell(softstart_active));
    cover property (skip_count == 3'h7);
endmodule // vsss_chk

bind vsss_ctrl vsss_chk #(.UPD_CYC(UPD_CYC), .SS_STEP_CYC(SS_STEP_CYC))
    u_chk (.clk, .rstn, .supply_on, .cs_trip, .max_off_interval,
    .ring_supp_done, .startup_charge_en, .gate_drive, .cs_limit_mv,
    .skip_count, .zc_count, .softstart_active);

//--- bench/vsss_far.sv
// Purpose: comparators and power switch around the core
// Assumes: ringing falls every 8 off cycles
// Notes: slow models ringing that damps out
`timescale 1ns/1ps
module vsss_far #(
    parameter int ON_CYC = 6,
    parameter int RS_CYC = 4,
    parameter int OFF_MAX = 100
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic gate_drive,
    input wire logic slow,
    output logic zero_cross_input,
    output logic cs_trip,
    output logic ring_supp_done,
    output logic max_off_interval
);
    // ==========
    // Cycles since gate change
    logic g_q;
    logic [7:0] n_q;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            g_q <= 1'b0;
            n_q <= 8'h00;
        end else begin
            g_q <= gate_drive;
            if (gate_drive != g_q)
                n_q <= 8'h00;
            else if (n_q != 8'hFF)
                n_q <= n_q + 8'h01;
        end
    end
    assign cs_trip = g_q && n_q >= ON_CYC;
    assign ring_supp_done = !g_q && n_q >= RS_CYC;
    assign zero_cross_input = g_q || slow || !n_q[2];
    assign max_off_interval = !g_q && n_q >= OFF_MAX;
endmodule // vsss_far

//--- bench/tb.sv
// Purpose: scenario bench for vsss_ctrl
// Assumes: shortened update and step counts
// Notes: far side is vsss_far
`timescale 1ns/1ps
module tb;
    localparam int UPD = 200;
    localparam int SS = 50;
    logic clk = 0, rstn = 0, supply_on = 0, slow = 0, line_high = 0;
    logic fb_above_low = 0, fb_above_high = 0, fb_above_reset = 0;
    logic [9:0] ext_limit_mv = 10'h3FF;
    logic zero_cross_input, cs_trip, ring_supp_done, max_off_interval;
    logic startup_charge_en, gate_drive, softstart_active, hold_thr_sel;
    logic [9:0] cs_limit_mv;
    logic [2:0] skip_count, zc_count;
    int n_mismatch = 0;
    int checks = 0;
    vsss_ctrl #(.UPD_CYC(UPD), .SS_STEP_CYC(SS)) dut (.clk, .rstn,
        .supply_on, .zero_cross_input, .fb_above_low, .fb_above_high,
        .fb_above_reset, .cs_trip, .ring_supp_done, .max_off_interval,
        .line_high, .ext_limit_mv, .startup_charge_en, .gate_drive,
        .cs_limit_mv, .skip_count, .zc_count, .softstart_active,
        .hold_thr_sel);
    vsss_far #(.RS_CYC(10)) far (.clk, .rstn, .gate_drive, .slow,
        .zero_cross_input, .cs_trip, .ring_supp_done, .max_off_interval);
    initial begin
        forever #20 clk = ~clk;
    end
    // ==========
    // Helpers
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask
    task automatic end_of_test();
        $display("checks %0d n_mismatch %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic ok, input string m);
        checks++;
        if (ok !== 1'b1) begin
            n_mismatch++;
            $display("MISMATCH %0t %s", $time, m);
        end
    endtask
    task automatic wait_on(input logic ss, input logic v, input int n);
        for (int i = 0; i < n && (ss ? softstart_active : gate_drive) !== v;
             i++)
            cyc(1);
        chk((ss ? softstart_active : gate_drive) === v, "wait ran out");
        if (n_mismatch > 0)
            end_of_test();
    endtask
    task automatic period(input logic [2:0] f, input logic [2:0] e);
        cyc(60);
        {fb_above_low, fb_above_high, fb_above_reset} = f;
        cyc(f[0] ? 2 : 80);
        {fb_above_low, fb_above_high, fb_above_reset} = 3'h0;
        cyc(f[0] ? 138 : 60);
        chk(skip_count === e, "skip after period");
    endtask
    // ==========
    // Scenarios
    task automatic t_start();
        logic [9:0] lims [5] = '{10'h140, 10'h1F0, 10'h2A0, 10'h350, 10'h3E8};
        chk(skip_count === 3'h1, "skip after reset");
        chk(startup_charge_en === 1'b1, "charge off in reset");
        supply_on = 1'b1;
        line_high = 1'b1;
        wait_on(1'b1, 1'b1, 10);
        cyc(2);
        chk(startup_charge_en === 1'b0, "charge still on");
        chk(hold_thr_sel === 1'b1, "threshold select");
        for (int k = 0; k < 5; k++) begin
            chk(cs_limit_mv === lims[k], "soft-start limit");
            chk(softstart_active === (k < 4), "soft-start span");
            cyc(SS);
        end
        ext_limit_mv = 10'h258;
        cyc(2);
        chk(cs_limit_mv === 10'h258, "lower limit ignored");
        ext_limit_mv = 10'h3FF;
        line_high = 1'b0;
        cyc(3);
        chk(hold_thr_sel === 1'b0, "threshold select low");
    endtask
    task automatic t_skip();
        logic [2:0] s;
        s = skip_count;
        for (int i = 0; i < UPD + 10 && skip_count === s; i++)
            cyc(1);
        chk(skip_count === s + 3'h1, "no increment");
        cyc(10);
        for (int k = s + 2; k <= 8; k++)
            period(3'h0, (k > 7) ? 3'h7 : 3'(k));
        period(3'h4, 3'h7);
        period(3'h6, 3'h6);
        period(3'h4, 3'h6);
        period(3'h7, 3'h1);
        period(3'h6, 3'h1);
    endtask
    task automatic t_switch();
        wait_on(1'b0, 1'b0, 30);
        wait_on(1'b0, 1'b1, 100);
        chk(zc_count === 3'h1, "on before crossing");
        cyc(1);
        chk(zc_count === 3'h0, "crossings kept");
        slow = 1'b1;
        wait_on(1'b0, 1'b0, 30);
        wait_on(1'b0, 1'b1, 150);
        chk(zc_count === 3'h0, "forced on missing");
    endtask
    initial begin
        cyc(5);
        rstn = 1'b1;
        t_start();
        t_skip();
        t_switch();
        end_of_test();
    end
endmodule // tb
